// >>> rtl/ssu_detect.sv
`default_nettype none
// classifies one sram access into error events
module ssu_detect (
  // access from the sram side
  input  wire logic        acc_rd_i,
  input  wire logic        acc_wr_i,
  input  wire logic [15:0] acc_addr_i,
  input  wire logic        ecc_single_i,
  input  wire logic        ecc_double_i,
  input  wire logic        addr_fault_i,
  // events out
  ssu_err_if.det           err
);
  ////////////////////////////////////////////////////////////////////////
  // ecc is only meaningful on a read; write data is not checked here
  assign err.corr     = acc_rd_i & ecc_single_i & ~ecc_double_i;
  assign err.uncorr   = acc_rd_i & ecc_double_i;
  // address decode fault is checked on both directions
  assign err.addr_err = (acc_rd_i | acc_wr_i) & addr_fault_i;
  assign err.addr     = acc_addr_i;
endmodule : ssu_detect
`default_nettype wire

// >>> rtl/ssu_err_if.sv
`default_nettype none
// error events from the detector to the recorder
interface ssu_err_if;
  logic        corr;       // correctable ecc error, one cycle
  logic        uncorr;     // uncorrectable ecc error, one cycle
  logic        addr_err;   // address error, one cycle
  logic [15:0] addr;       // access address of the event
  modport det (output corr, output uncorr, output addr_err, output addr);
  modport rec (input corr, input uncorr, input addr_err, input addr);
endinterface : ssu_err_if
`default_nettype wire

// >>> rtl/ssu_pkg.sv
`default_nettype none
package ssu_pkg;
  // register offsets (byte addresses, 32-bit words)
  localparam logic [7:0] OFS_ECC_DETECT   = 8'h00;
  localparam logic [7:0] OFS_FAULT_STATUS = 8'h04;
  localparam logic [7:0] OFS_ERROR_INFO   = 8'h08;
  localparam logic [7:0] OFS_MEM_CONTROL  = 8'h0C;
  localparam logic [7:0] OFS_ALARM_GROUP  = 8'h10;
  // ecc detect register fields
  localparam int ECC_CORR_BIT   = 0;
  localparam int ECC_UNCORR_BIT = 1;
  localparam int ECC_ADDR_BIT   = 2;
  // fault status: operation error bit zero
  localparam int FLT_OPERR0_BIT = 0;
  // alarm group status flag ten (data memory uncorrectable critical)
  localparam int AG_STATUS_FLAG_TEN_BIT    = 10;
  localparam int AG1_SHIFT      = 16;
  // error info fields
  localparam int EI_ADDR_W      = 16;
  localparam int EI_KIND_LSB    = 16;
  localparam int EI_VALID_BIT   = 31;
  // memory control reserved storage bits, alarm enable bit, write mask and reset value
  localparam int MC_R8_BIT      = 8;
  localparam int MC_R12_BIT     = 12;
  localparam int MC_R13_BIT     = 13;
  localparam int MC_R14_BIT     = 14;
  localparam int MC_ALM_EN_BIT  = 0;
  localparam logic [31:0] MC_WRITE_MASK  = 32'h0000_7101;
  localparam logic [31:0] MC_RESET_VALUE = 32'h0000_4001;
  localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;
  // error kind codes
  typedef enum logic [2:0] {
    SSU_KIND_NONE   = 3'h0,
    SSU_KIND_CORR   = 3'h1,
    SSU_KIND_UNCORR = 3'h2,
    SSU_KIND_ADDR   = 3'h4
  } ssu_kind_type;
endpackage : ssu_pkg
`default_nettype wire

// >>> rtl/ssu_top.sv
// Added by the designer: the address-and-strobe port and the register addresses.
`default_nettype none
// What this block does
// - correctable ecc error detected on reads only
// - uncorrectable ecc error detected on reads
// - address error detected on reads and writes
// - alarm sent on the erring access itself
// - status stored regardless of alarm propagation
// - pending alarms flushed on any sram read while alarms are enabled
// - reset alone sets no alarm or status
// - data memory uncorrectable sets flag ten, operr0
// - error info written only for real errors
// - control bits 8,12,13,14 are read/write
// - errors also signalled to owning module
module ssu_top #(
  parameter bit IS_DATA_MEM = 1'b1  // instance guards a cpu data memory
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  // sram access observation
  input  wire logic        acc_rd_i,
  input  wire logic        acc_wr_i,
  input  wire logic [15:0] acc_addr_i,
  input  wire logic        ecc_single_i,
  input  wire logic        ecc_double_i,
  input  wire logic        addr_fault_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // alarms to safety management unit
  output logic             alm_corr_o,
  output logic             alm_uncorr_o,
  output logic             alm_addr_o,
  // notification to owning module
  output logic             own_corr_o,
  output logic             own_uncorr_o,
  output logic             own_addr_o
);
  ////////////////////////////////////////////////////////////////////////
  // detector
  ssu_err_if ev ();

  ssu_detect u_detect (
    .acc_rd_i     (acc_rd_i),
    .acc_wr_i     (acc_wr_i),
    .acc_addr_i   (acc_addr_i),
    .ecc_single_i (ecc_single_i),
    .ecc_double_i (ecc_double_i),
    .addr_fault_i (addr_fault_i),
    .err          (ev)
  );

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [2:0]  ecc_det_r,  ecc_det_nxt;   // sticky ecc detect flags
  logic [31:0] fault_r,    fault_nxt;     // fault status
  logic [31:0] einfo_r,    einfo_nxt;     // error information
  logic [31:0] mctl_r,     mctl_nxt;      // memory control
  logic [31:0] agrp_r,     agrp_nxt;      // alarm group flags
  logic [2:0]  pend_r,     pend_nxt;      // alarms held while masked
  logic [2:0]  alm_r,      alm_nxt;       // alarm pulses
  logic [2:0]  own_r,      own_nxt;       // owner pulses
  logic [31:0] rdata_r,    rdata_nxt;     // read data
  logic [2:0]  evt;                       // this cycle's events
  logic        alm_en;                    // propagation enable

  // decode helper, shared by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  assign evt    = {ev.addr_err, ev.uncorr, ev.corr};
  assign alm_en = mctl_r[ssu_pkg::MC_ALM_EN_BIT];

  ////////////////////////////////////////////////////////////////////////
  // next-state logic for records, alarms and register reads
  always_comb begin
    ecc_det_nxt = ecc_det_r;
    fault_nxt   = fault_r;
    einfo_nxt   = einfo_r;
    mctl_nxt    = mctl_r;
    agrp_nxt    = agrp_r;
    pend_nxt    = pend_r;
    alm_nxt     = 3'h0;
    rdata_nxt   = ssu_pkg::ZERO_WORD;
    // owner always hears about errors, whatever the alarm path does
    own_nxt     = evt;
    // software clears first (write one to clear, error info on any write); set below wins
    if (reg_wr_i) begin
      if (hit(reg_addr_i, ssu_pkg::OFS_ECC_DETECT)) begin
        ecc_det_nxt = ecc_det_r & ~reg_wdata_i[2:0];
      end
      if (hit(reg_addr_i, ssu_pkg::OFS_FAULT_STATUS)) begin
        fault_nxt = fault_r & ~reg_wdata_i;
      end
      if (hit(reg_addr_i, ssu_pkg::OFS_ERROR_INFO)) begin
        einfo_nxt = ssu_pkg::ZERO_WORD;
      end
      if (hit(reg_addr_i, ssu_pkg::OFS_ALARM_GROUP)) begin
        agrp_nxt = agrp_r & ~reg_wdata_i;
      end
      if (hit(reg_addr_i, ssu_pkg::OFS_MEM_CONTROL)) begin
        // reserved bits are plain storage, software keeps their values
        mctl_nxt = reg_wdata_i & ssu_pkg::MC_WRITE_MASK;
      end
    end
    // status recorded for every event, even when alarms are held back
    ecc_det_nxt = ecc_det_nxt | evt;
    if (|evt) begin
      fault_nxt[ssu_pkg::FLT_OPERR0_BIT] = fault_nxt[ssu_pkg::FLT_OPERR0_BIT]
                                           | (IS_DATA_MEM & ev.uncorr);
      // only a real event writes info, so zero means not a real error
      einfo_nxt = {1'b1, 12'h000, evt, ev.addr};
    end
    if (IS_DATA_MEM && ev.uncorr) begin
      agrp_nxt[ssu_pkg::AG_STATUS_FLAG_TEN_BIT] = 1'b1;
      agrp_nxt[ssu_pkg::AG1_SHIFT + ssu_pkg::AG_STATUS_FLAG_TEN_BIT] = 1'b1;
    end
    // alarm propagation
    if (alm_en) begin
      // fire on the erring access itself, plus anything held if the access is a read
      if (acc_rd_i) begin
        alm_nxt  = evt | pend_r;
        pend_nxt = 3'h0;
      end else begin
        alm_nxt  = evt;
      end
    end else begin
      // held events wait for the next read after re-enable
      pend_nxt = pend_r | evt;
    end
    // register read data for the next cycle
    if (reg_rd_i) begin
      if (hit(reg_addr_i, ssu_pkg::OFS_ECC_DETECT)) begin
        rdata_nxt = {29'h0000_0000, ecc_det_r};
      end else if (hit(reg_addr_i, ssu_pkg::OFS_FAULT_STATUS)) begin
        rdata_nxt = fault_r;
      end else if (hit(reg_addr_i, ssu_pkg::OFS_ERROR_INFO)) begin
        rdata_nxt = einfo_r;
      end else if (hit(reg_addr_i, ssu_pkg::OFS_MEM_CONTROL)) begin
        rdata_nxt = mctl_r;
      end else if (hit(reg_addr_i, ssu_pkg::OFS_ALARM_GROUP)) begin
        rdata_nxt = agrp_r;
      end else begin
        rdata_nxt = ssu_pkg::ZERO_WORD;   // unmapped reads zero
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers; reset leaves every flag clear, never a spurious alarm
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ecc_det_r <= 3'h0;
      fault_r   <= ssu_pkg::ZERO_WORD;
      einfo_r   <= ssu_pkg::ZERO_WORD;
      mctl_r    <= ssu_pkg::MC_RESET_VALUE;
      agrp_r    <= ssu_pkg::ZERO_WORD;
      pend_r    <= 3'h0;
      alm_r     <= 3'h0;
      own_r     <= 3'h0;
      rdata_r   <= ssu_pkg::ZERO_WORD;
    end else begin
      ecc_det_r <= ecc_det_nxt;
      fault_r   <= fault_nxt;
      einfo_r   <= einfo_nxt;
      mctl_r    <= mctl_nxt;
      agrp_r    <= agrp_nxt;
      pend_r    <= pend_nxt;
      alm_r     <= alm_nxt;
      own_r     <= own_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, one line per alarm kind
  assign alm_corr_o   = alm_r[0];
  assign alm_uncorr_o = alm_r[1];
  assign alm_addr_o   = alm_r[2];
  assign own_corr_o   = own_r[0];
  assign own_uncorr_o = own_r[1];
  assign own_addr_o   = own_r[2];
  assign reg_rdata_o  = rdata_r;
endmodule : ssu_top
`default_nettype wire

// >>> testbench/ssu_sram_model.sv
`default_nettype none
// sram side: one access per call, error flags left stale afterwards
module ssu_sram_model (
  input  wire logic        sys_clk_i,
  output logic             acc_rd_o,
  output logic             acc_wr_o,
  output logic      [15:0] addr_o,
  output logic      [2:0]  err_o     // {address fault, double, single}
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    acc_rd_o = 1'b0;
    acc_wr_o = 1'b0;
    addr_o   = 16'h0000;
    err_o    = 3'h0;
  end
  // flags are not cleared after the strobe: the block must ignore them then
  task automatic access(input logic rd, input logic [2:0] err, input logic [15:0] a);
    @(posedge sys_clk_i);
    acc_rd_o <= rd;
    acc_wr_o <= !rd;
    addr_o   <= a;
    err_o    <= err;
    @(posedge sys_clk_i);
    acc_rd_o <= 1'b0;
    acc_wr_o <= 1'b0;
    addr_o   <= ~a;
  endtask : access
endmodule : ssu_sram_model
`default_nettype wire

// >>> testbench/ssu_top_assertions.sv
`default_nettype none
// watches the alarm and owner pulses against the sram access that caused them
module ssu_top_assertions (
  // clock and reset
  input wire logic        sys_clk_i,
  input wire logic        reset_n_i,
  // sram access and register write port
  input wire logic        acc_rd_i,
  input wire logic        acc_wr_i,
  input wire logic        ecc_single_i,
  input wire logic        ecc_double_i,
  input wire logic        addr_fault_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  // alarm and owner pulses
  input wire logic        alm_corr_o,
  input wire logic        alm_uncorr_o,
  input wire logic        alm_addr_o,
  input wire logic        own_corr_o,
  input wire logic        own_uncorr_o,
  input wire logic        own_addr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////////////////
  logic en_r;   // shadow of the alarm enable bit
  logic en_nxt; // its next value
  // shadow follows control writes, so gating is known without a read
  always_comb begin
    en_nxt = en_r;
    if (reg_wr_i && reg_addr_i == ssu_pkg::OFS_MEM_CONTROL) begin
      en_nxt = reg_wdata_i[ssu_pkg::MC_ALM_EN_BIT];
    end
  end
  // reset value of the enable bit is one
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      en_r <= 1'b1;
    end else begin
      en_r <= en_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  sequence s_rd_uncorr;
    acc_rd_i && ecc_double_i;
  endsequence
  sequence s_rd_corr;
    acc_rd_i && ecc_single_i && !ecc_double_i;
  endsequence
  sequence s_quiet;
    !alm_corr_o && !alm_uncorr_o && !alm_addr_o && !own_corr_o && !own_uncorr_o
      && !own_addr_o;
  endsequence
  a_corr_read_only: assert property (s_rd_corr |=> own_corr_o)
    else $error("correctable read gave no owner pulse");
  a_no_ecc_write: assert property (!acc_rd_i |=> !own_corr_o && !own_uncorr_o)
    else $error("ecc event without a read");
  a_uncorr_owner: assert property (s_rd_uncorr |=> own_uncorr_o)
    else $error("uncorrectable read gave no owner pulse");
  a_addr_any_access: assert property ((acc_rd_i || acc_wr_i) && addr_fault_i |=> own_addr_o)
    else $error("address error gave no owner pulse");
  a_alarm_same_access: assert property (en_r ##0 s_rd_uncorr |=> alm_uncorr_o)
    else $error("uncorrectable alarm not on the erring access");
  a_alarm_needs_access: assert property (alm_corr_o || alm_uncorr_o |-> $past(acc_rd_i))
    else $error("ecc alarm without a read");
  a_gated_alarm_quiet: assert property (!en_r |=> !alm_corr_o && !alm_uncorr_o && !alm_addr_o)
    else $error("alarm while gated");
  a_quiet_after_reset: assert property ($rose(reset_n_i) |-> s_quiet)
    else $error("pulse right after reset");
endmodule : ssu_top_assertions
bind ssu_top ssu_top_assertions u_chk (.sys_clk_i, .reset_n_i, .acc_rd_i, .acc_wr_i,
  .ecc_single_i, .ecc_double_i, .addr_fault_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .alm_corr_o, .alm_uncorr_o, .alm_addr_o, .own_corr_o, .own_uncorr_o, .own_addr_o);
`default_nettype wire

// >>> testbench/ssu_top_tb_top.sv
`default_nettype none
module ssu_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk_i;
  logic        reset_n_i;
  logic        rd;
  logic        wr;
  logic [15:0] addr;
  logic [2:0]  err;
  logic [7:0]  ra;
  logic [31:0] wd;
  logic        rw;
  logic        rr;
  logic [31:0] rdata;
  logic [2:0]  alm;
  logic [2:0]  own;
  int          fail_count = 0;
  int          checks_done = 0;
  ssu_sram_model u_ssu_sram_model (.sys_clk_i(sys_clk_i), .acc_rd_o(rd), .acc_wr_o(wr),
    .addr_o(addr), .err_o(err));
  ssu_top u_ssu_top (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .acc_rd_i(rd),
    .acc_wr_i(wr), .acc_addr_i(addr), .ecc_single_i(err[0]), .ecc_double_i(err[1]),
    .addr_fault_i(err[2]), .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(rw), .reg_rd_i(rr),
    .reg_rdata_o(rdata), .alm_corr_o(alm[0]), .alm_uncorr_o(alm[1]), .alm_addr_o(alm[2]),
    .own_corr_o(own[0]), .own_uncorr_o(own[1]), .own_addr_o(own[2]));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    ra <= a;
    wd <= d;
    rw <= 1'b1;
    @(posedge sys_clk_i);
    rw <= 1'b0;
  endtask : reg_write
  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk_i);
    ra <= a;
    rr <= 1'b1;
    @(posedge sys_clk_i);
    rr <= 1'b0;
    #1 chk(rdata, exp);
  endtask : reg_read
  // pulses are looked at in the one cycle they stand
  task automatic sram(input logic r, input logic [2:0] e, input logic [15:0] a,
                      input logic [2:0] exp_alm, input logic [2:0] exp_own);
    u_ssu_sram_model.access(r, e, a);
    #1 chk({29'h0, alm}, {29'h0, exp_alm});
    chk({29'h0, own}, {29'h0, exp_own});
  endtask : sram
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  initial begin
    #50000;
    fail_count++;
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n_i, ra, wd, rw, rr} = '0;
    repeat (20) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    reg_read(ssu_pkg::OFS_ECC_DETECT, 32'h0000_0000);
    reg_read(ssu_pkg::OFS_FAULT_STATUS, 32'h0000_0000);
    reg_read(ssu_pkg::OFS_ALARM_GROUP, 32'h0000_0000);
    reg_read(ssu_pkg::OFS_ERROR_INFO, 32'h0000_0000);
    reg_read(ssu_pkg::OFS_MEM_CONTROL, 32'h0000_4001);
    reg_write(ssu_pkg::OFS_MEM_CONTROL, 32'h0000_7101);
    reg_read(ssu_pkg::OFS_MEM_CONTROL, 32'h0000_7101);
    reg_write(ssu_pkg::OFS_MEM_CONTROL, 32'h0000_4001);
    reg_read(ssu_pkg::OFS_MEM_CONTROL, 32'h0000_4001);
    reg_read(8'hFC, 32'h0000_0000);
    $display("reset and control test done");
    sram(1'b1, 3'h2, 16'h1234, 3'h2, 3'h2);
    reg_read(ssu_pkg::OFS_ECC_DETECT, 32'h0000_0002);
    reg_read(ssu_pkg::OFS_FAULT_STATUS, 32'h0000_0001);
    reg_read(ssu_pkg::OFS_ALARM_GROUP, 32'h0400_0400);
    reg_read(ssu_pkg::OFS_ERROR_INFO, 32'h8002_1234);
    reg_write(ssu_pkg::OFS_ECC_DETECT, 32'h0000_0007);
    reg_write(ssu_pkg::OFS_FAULT_STATUS, 32'h0000_0001);
    reg_write(ssu_pkg::OFS_ALARM_GROUP, 32'hFFFF_FFFF);
    reg_write(ssu_pkg::OFS_ERROR_INFO, 32'h0000_0000);
    reg_read(ssu_pkg::OFS_ALARM_GROUP, 32'h0000_0000);
    $display("uncorrectable test done");
    sram(1'b0, 3'h3, 16'h0010, 3'h0, 3'h0);
    sram(1'b0, 3'h4, 16'h0020, 3'h4, 3'h4);
    reg_read(ssu_pkg::OFS_ECC_DETECT, 32'h0000_0004);
    sram(1'b1, 3'h1, 16'h0022, 3'h1, 3'h1);
    reg_write(ssu_pkg::OFS_ECC_DETECT, 32'h0000_0007);
    $display("access kind test done");
    reg_write(ssu_pkg::OFS_MEM_CONTROL, 32'h0000_4000);
    sram(1'b1, 3'h1, 16'h0030, 3'h0, 3'h1);
    reg_read(ssu_pkg::OFS_ECC_DETECT, 32'h0000_0001);
    reg_write(ssu_pkg::OFS_MEM_CONTROL, 32'h0000_4001);
    sram(1'b1, 3'h0, 16'h0040, 3'h1, 3'h0);
    $display("gated alarm test done");
    // records and a held alarm, then a reset in mid-run must wipe them all
    reg_write(ssu_pkg::OFS_MEM_CONTROL, 32'h0000_4000);
    sram(1'b1, 3'h2, 16'h0050, 3'h0, 3'h2);
    @(posedge sys_clk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    reg_read(ssu_pkg::OFS_ECC_DETECT, 32'h0000_0000);
    reg_read(ssu_pkg::OFS_FAULT_STATUS, 32'h0000_0000);
    reg_read(ssu_pkg::OFS_ALARM_GROUP, 32'h0000_0000);
    reg_read(ssu_pkg::OFS_ERROR_INFO, 32'h0000_0000);
    reg_read(ssu_pkg::OFS_MEM_CONTROL, 32'h0000_4001);
    reg_write(ssu_pkg::OFS_ALARM_GROUP, 32'hFFFF_FFFF);
    sram(1'b1, 3'h0, 16'h0060, 3'h0, 3'h0);
    $display("mid-run reset test done");
    final_report();
  end
endmodule : ssu_top_tb_top
`default_nettype wire
